// ==== pbsc_pkg.sv ====
// constants and types shared by the pipelined burst sram control block
`default_nettype none
package pbsc_pkg;
   // -------------------------------------------------------------------
   // array geometry
   // -------------------------------------------------------------------
   localparam int ADDR_W     = 17;
   localparam int DATA_W     = 32;
   localparam int LANE_N     = 4;
   localparam int LANE_W     = 8;
   localparam int WORD_N     = 131072;
   localparam int BURST_W    = 2;
   localparam int FIFO_DEPTH = 32;

   // -------------------------------------------------------------------
   // reset values and codes
   // -------------------------------------------------------------------
   localparam logic [LANE_N-1:0]  LANES_ALL  = 4'hf;
   localparam logic [LANE_N-1:0]  LANES_NONE = 4'h0;
   localparam logic [BURST_W-1:0] CNT_RST    = 2'h0;
   localparam logic [BURST_W-1:0] CNT_STEP   = 2'h1;
   localparam logic [ADDR_W-1:0]  ADDR_RST   = 17'h00000;
   localparam logic [DATA_W-1:0]  DATA_RST   = 32'h0000_0000;

   // cycle kind held between edges
   typedef enum logic [1:0] {CYC_IDLE, CYC_READ, CYC_WRITE} pbsc_cyc_e;

   // one buffered write: word address, lanes to update, data
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANE_N-1:0] lanes;
      logic [DATA_W-1:0] data;
   } pbsc_wreq_s;

   localparam int WREQ_W = $bits(pbsc_wreq_s);
endpackage
`default_nettype wire

// ==== pbsc_stream_if.sv ====
// valid/ready stream carrier between the block's own modules
`timescale 1ns/10ps
`default_nettype none
interface pbsc_stream_if #(parameter int W = 8) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   // producer side
   modport src (output valid, output data, input ready);
   // consumer side
   modport snk (input valid, input data, output ready);
endinterface // pbsc_stream_if
`default_nettype wire

// ==== pbsc_fifo.sv ====
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module pbsc_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic   clk_i,
   input  wire logic   rstn_i,
   // streams
   pbsc_stream_if.snk  in_s,
   pbsc_stream_if.src  out_s
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [W-1:0]     mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0]   cnt_reg;
   logic             push;
   logic             pop;

   // -------------------------------------------------------------------
   // handshakes: full and empty come straight from the fill count
   // -------------------------------------------------------------------
   assign in_s.ready  = (cnt_reg != (PTR_W+1)'(DEPTH));
   assign out_s.valid = (cnt_reg != '0);
   assign out_s.data  = mem[rd_ptr_reg];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   // storage is not reset; only pointers matter
   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_s.data;
   end

   // pointers wrap naturally at a power-of-two depth
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
      end
   end

   // fill count
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         cnt_reg <= '0;
      else if (push && !pop)
         cnt_reg <= cnt_reg + (PTR_W+1)'(1);
      else if (pop && !push)
         cnt_reg <= cnt_reg - (PTR_W+1)'(1);
   end
endmodule // pbsc_fifo
`default_nettype wire

// ==== pbsc_store.sv ====
// word array with per-lane write from a stream and an asynchronous read port
`timescale 1ns/10ps
`default_nettype none
module pbsc_store (
   // clock
   input  wire logic                 clk_i,
   // write stream and drain stall
   pbsc_stream_if.snk                wr_s,
   input  wire logic                 stall_i,
   // read port
   input  wire logic [pbsc_pkg::ADDR_W-1:0] rd_addr_i,
   output logic [pbsc_pkg::DATA_W-1:0]      rd_data_o
);
   import pbsc_pkg::*;

   pbsc_wreq_s req;

   // a stalled drain lets the buffer in front of us fill up
   assign wr_s.ready = !stall_i;
   assign req        = pbsc_wreq_s'(wr_s.data);

   // -------------------------------------------------------------------
   // one array per byte lane, so each lane writes on its own
   // -------------------------------------------------------------------
   for (genvar g = 0; g < LANE_N; g++)
   begin : g_lane
      logic [LANE_W-1:0] lane_mem [WORD_N];

      // contents are never cleared, so they survive sleep and reset
      always_ff @(posedge clk_i)
      begin
         if (wr_s.valid && !stall_i && req.lanes[g])                  // [R03] [R04]
            lane_mem[req.addr] <= req.data[g*LANE_W +: LANE_W];        // [R10]
      end

      assign rd_data_o[g*LANE_W +: LANE_W] = lane_mem[rd_addr_i];
   end
endmodule // pbsc_store
`default_nettype wire

// ==== pbsc_burst_sram.sv ====
// top of the pipelined burst sram: cycle decode, burst counter, output pipe
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [R01] primary select high ignores processor start; with controller start it deselects.
// [R02] expansion selects active high and low; new access needs all three selects.
// [R03] global write low writes all four lanes whatever the other strobes say.
// [R04] write gate low, global high: lanes with low byte strobe written; none is read.
// [R05] far side using byte strobes only should tie global write high.
// [R06] far side using byte strobes only should tie write gate low.
// [R07] write cycle: global write low, or write gate low with a byte strobe low.
// [R08] sleep input enters lowest power and freezes internal state at once.
// [R09] after sleep release stay low power until a read or write begins.
// [R10] stored words unchanged across sleep entry, residence and exit.
// [R11] output enable is not clocked; bus drives as soon as it falls in a read.
// [R12] far side raises output enable before a write after a read and holds it.
// [R13] processor start begins a read; controller start reads or writes by strobes.
// [R14] begin write uses external address, bus stays off, data stored in lanes.
// [R15] no start and step low continues the burst at the next address.
// [R16] no start and step high repeats the current address, counter held.
// [R17] read drives all lanes only with output enable low; else high impedance.
// [R18] either start aborts a burst and captures a fresh external address.
// [R19] step advances two-bit counter: linear when order low, interleaved when high.
// [R20] read data passes an output register, one cycle of pipeline latency.
// [R21] interleaved order xors counter with start address low bits, wraps in four.
module pbsc_burst_sram (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rstn_i,
   // address and selects
   input  wire logic [pbsc_pkg::ADDR_W-1:0]   address_in_i,
   input  wire logic                          primary_select_n_i,
   input  wire logic                          expansion_select_hi_i,
   input  wire logic                          expansion_select_lo_n_i,
   // burst control
   input  wire logic                          processor_burst_start_n_i,
   input  wire logic                          controller_burst_start_n_i,
   input  wire logic                          burst_step_n_i,
   input  wire logic                          burst_order_select_i,
   // write strobes
   input  wire logic                          all_byte_write_n_i,
   input  wire logic                          write_gate_n_i,
   input  wire logic [pbsc_pkg::LANE_N-1:0]   byte_lane_write_n_i,
   // asynchronous controls
   input  wire logic                          output_enable_n_i,
   input  wire logic                          sleep_request_i,
   // data lanes, split two-way pin
   input  wire logic [pbsc_pkg::DATA_W-1:0]   data_lane_i,
   output logic      [pbsc_pkg::DATA_W-1:0]   data_lane_o,
   output logic      [pbsc_pkg::LANE_N-1:0]   data_lane_oe_n_o,
   // status
   output logic                               low_power_o,
   output logic                               wr_buf_ready_o
);
   import pbsc_pkg::*;

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   pbsc_cyc_e            cyc_reg;
   pbsc_cyc_e            cyc_next;
   logic [ADDR_W-1:0]    base_reg;
   logic [BURST_W-1:0]   cnt_reg;
   logic [BURST_W-1:0]   cnt_next;
   logic                 low_power_reg;
   logic                 drive_reg;
   logic [DATA_W-1:0]    dout_reg;
   logic                 awake;
   logic                 all_sel;
   logic                 proc_start;
   logic                 any_start;
   logic                 begin_go;
   logic                 desel_go;
   logic                 burst_go;
   logic                 step;
   logic [LANE_N-1:0]    wr_lanes;
   logic                 is_wr;
   logic [ADDR_W-1:0]    cur_addr;
   logic [ADDR_W-1:0]    step_addr;
   logic [ADDR_W-1:0]    wr_addr;
   logic [DATA_W-1:0]    rd_data;
   logic                 bus_on;
   pbsc_wreq_s           push_req;

   pbsc_stream_if #(.W(WREQ_W)) push_s ();
   pbsc_stream_if #(.W(WREQ_W)) pop_s ();

   // -------------------------------------------------------------------
   // burst address generation
   // -------------------------------------------------------------------
   // low address bits for a given count, in the selected order
   function automatic logic [BURST_W-1:0] burst_low(
      input logic [BURST_W-1:0] start_lo,
      input logic [BURST_W-1:0] cnt,
      input logic               interleave
   );
      if (interleave)
         return start_lo ^ cnt;                                       // [R21]
      return start_lo + cnt;                                          // [R19]
   endfunction

   // upper bits stay fixed, so a burst wraps inside its four-word block
   assign cnt_next  = cnt_reg + CNT_STEP;
   assign cur_addr  = {base_reg[ADDR_W-1:BURST_W],
                       burst_low(base_reg[BURST_W-1:0], cnt_reg, burst_order_select_i)};
   assign step_addr = {base_reg[ADDR_W-1:BURST_W],
                       burst_low(base_reg[BURST_W-1:0], cnt_next, burst_order_select_i)};

   // -------------------------------------------------------------------
   // cycle decode
   // -------------------------------------------------------------------
   // the begin, deselect, burst and step terms are gated off while sleep is requested, the stand-in for a stopped clock
   always_comb
   begin
      awake      = !sleep_request_i;                                  // [R08]
      all_sel    = !primary_select_n_i && expansion_select_hi_i
                   && !expansion_select_lo_n_i;                       // [R02]
      proc_start = !processor_burst_start_n_i && !primary_select_n_i; // [R01]
      any_start  = proc_start || !controller_burst_start_n_i;         // [R18]
      begin_go   = awake && any_start && all_sel;                     // [R02]
      desel_go   = awake && any_start && !all_sel;                    // [R01]
      burst_go   = awake && !any_start && (cyc_reg != CYC_IDLE) && !low_power_reg;
      step       = burst_go && !burst_step_n_i;                       // [R15]
   end

   // lane qualification: global write wins over gate and byte strobes
   always_comb
   begin
      if (!all_byte_write_n_i)
         wr_lanes = LANES_ALL;                                        // [R03]
      else if (!write_gate_n_i)
         wr_lanes = ~byte_lane_write_n_i;                             // [R04]
      else
         wr_lanes = LANES_NONE;
      is_wr = (wr_lanes != LANES_NONE);                               // [R07]
   end

   // next cycle kind
   always_comb
   begin
      cyc_next = cyc_reg;
      if (!awake)
         cyc_next = cyc_reg;                                          // [R08]
      else if (begin_go && proc_start)
         cyc_next = CYC_READ;                                         // [R13]
      else if (begin_go)
         cyc_next = is_wr ? CYC_WRITE : CYC_READ;                     // [R13]
      else if (desel_go)
         cyc_next = CYC_IDLE;                                         // [R01]
      else if (burst_go)
         cyc_next = is_wr ? CYC_WRITE : CYC_READ;                     // [R15] [R16]
      else if (low_power_reg)
         cyc_next = CYC_IDLE;                                         // [R09]
   end

   // -------------------------------------------------------------------
   // burst state registers
   // -------------------------------------------------------------------
   // cycle kind
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         cyc_reg <= CYC_IDLE;
      else
         cyc_reg <= cyc_next;
   end

   // start address: only a begin captures it, a deselect leaves it
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         base_reg <= ADDR_RST;
      else if (begin_go)
         base_reg <= address_in_i;                                    // [R18] [R14]
   end

   // burst counter: cleared by a begin, held by suspend and by sleep
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         cnt_reg <= CNT_RST;
      else if (begin_go)
         cnt_reg <= CNT_RST;                                          // [R18]
      else if (step)
         cnt_reg <= cnt_next;                                         // [R19]
   end

   // low power: sleep sets it, and only a fresh begin clears it
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         low_power_reg <= 1'b0;
      else if (sleep_request_i)
         low_power_reg <= 1'b1;                                       // [R08]
      else if (begin_go)
         low_power_reg <= 1'b0;                                       // [R09]
   end

   // -------------------------------------------------------------------
   // write path through the buffer
   // -------------------------------------------------------------------
   // writes land at the address this edge selects: external, next or current
   assign wr_addr             = begin_go ? address_in_i : (step ? step_addr : cur_addr);
   assign push_req.addr       = wr_addr;                              // [R14] [R16]
   assign push_req.lanes      = wr_lanes;
   assign push_req.data       = data_lane_i;
   assign push_s.valid        = (cyc_next == CYC_WRITE) && (begin_go || burst_go);
   assign push_s.data         = push_req;
   assign wr_buf_ready_o      = push_s.ready;

   // the buffer holds pending writes while the drain is frozen by sleep; no write is pushed during sleep
   pbsc_fifo #(
      .W     (WREQ_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .in_s   (push_s),
      .out_s  (pop_s)
   );

   pbsc_store u_store (
      .clk_i     (clk_i),
      .wr_s      (pop_s),
      .stall_i   (sleep_request_i),                                   // [R10]
      .rd_addr_i (cur_addr),
      .rd_data_o (rd_data)
   );

   // -------------------------------------------------------------------
   // read pipeline and bus drivers
   // -------------------------------------------------------------------
   // output register: the address of edge n shows its data after edge n+1
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         dout_reg <= DATA_RST;
      else if (awake && (cyc_reg == CYC_READ))
         dout_reg <= rd_data;                                         // [R20]
   end

   // drive qualifier follows the read; sleep clears it so no stale drive outlives sleep
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         drive_reg <= 1'b0;
      else
         drive_reg <= awake && (cyc_reg == CYC_READ) && !low_power_reg; // [R20]
   end

   // output enable and sleep are combinational here, never sampled
   assign bus_on = drive_reg && !output_enable_n_i && !sleep_request_i // [R11] [R17]
                   && (cyc_reg != CYC_WRITE) && !low_power_reg;        // [R14]

   for (genvar g = 0; g < LANE_N; g++)
   begin : g_oe
      assign data_lane_oe_n_o[g] = !bus_on;                            // [R17]
   end

   assign data_lane_o = dout_reg;
   assign low_power_o = low_power_reg || sleep_request_i;

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   property p_desel;
      @(posedge clk_i) disable iff (!rstn_i)
      awake && primary_select_n_i && !controller_burst_start_n_i |=> cyc_reg == CYC_IDLE;
   endproperty
   a_desel: assert property (p_desel)                                 // [R01]
      else $error("controller start with primary select high did not deselect");
   property p_need_sel;
      @(posedge clk_i) disable iff (!rstn_i)
      awake && any_start && !expansion_select_hi_i |=> cyc_reg == CYC_IDLE;
   endproperty
   a_need_sel: assert property (p_need_sel)                           // [R02]
      else $error("access started without all selects");
   property p_global;
      @(posedge clk_i) disable iff (!rstn_i)
      push_s.valid && !all_byte_write_n_i |-> push_req.lanes == LANES_ALL;
   endproperty
   a_global: assert property (p_global)                               // [R03]
      else $error("global write did not select all lanes");
   property p_no_lane_read;
      @(posedge clk_i) disable iff (!rstn_i)
      begin_go && !proc_start && all_byte_write_n_i && write_gate_n_i
      |=> cyc_reg == CYC_READ ##1 drive_reg;
   endproperty
   a_no_lane_read: assert property (p_no_lane_read)                   // [R04] [R20]
      else $error("strobe-free begin was not a pipelined read");
   property p_proc_read;
      @(posedge clk_i) disable iff (!rstn_i)
      begin_go && proc_start |-> !push_s.valid ##1 cyc_reg == CYC_READ;
   endproperty
   a_proc_read: assert property (p_proc_read)                         // [R13]
      else $error("processor start did not begin a read");
   property p_abort;
      @(posedge clk_i) disable iff (!rstn_i)
      begin_go |=> base_reg == $past(address_in_i) && cnt_reg == CNT_RST;
   endproperty
   a_abort: assert property (p_abort)                                 // [R18]
      else $error("start did not capture a fresh address");
   property p_continue;
      @(posedge clk_i) disable iff (!rstn_i)
      step |=> cnt_reg == $past(cnt_reg) + CNT_STEP;
   endproperty
   a_continue: assert property (p_continue)                           // [R15] [R19]
      else $error("burst did not advance");

   property p_suspend;
      @(posedge clk_i) disable iff (!rstn_i)
      awake && !any_start && !burst_step_n_i == 1'b0 |=> $stable(cnt_reg);
   endproperty
   a_suspend: assert property (p_suspend)                             // [R16]
      else $error("suspend moved the burst counter");

   property p_sleep_hold;
      @(posedge clk_i) disable iff (!rstn_i)
      sleep_request_i [*2] |-> $stable(cnt_reg) && $stable(base_reg) && &data_lane_oe_n_o;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)                       // [R08]
      else $error("state moved or bus driven during sleep");

   property p_wake;
      @(posedge clk_i) disable iff (!rstn_i)
      low_power_reg && !begin_go |=> low_power_reg && !drive_reg;
   endproperty
   a_wake: assert property (p_wake)                                   // [R09]
      else $error("left low power without a begin");

   property p_oe;
      @(posedge clk_i) disable iff (!rstn_i)
      output_enable_n_i || (cyc_reg == CYC_WRITE) |-> data_lane_oe_n_o == LANES_ALL;
   endproperty
   a_oe: assert property (p_oe)                                       // [R11] [R17]
      else $error("bus driven with output enable high or in a write");
endmodule // pbsc_burst_sram
`default_nettype wire

// ==== pbsc_host_model.sv ====
// processor-side bus master model driving the burst sram's synchronous pins
`timescale 1ns/10ps
`default_nettype none
module pbsc_host_model
   import pbsc_pkg::*;
(
   // clock
   input  wire logic                   clk_i,
   // {order, step_n, controller start_n, processor start_n}
   output logic [3:0]                  start_o,
   // {expansion lo_n, expansion hi, primary_n}
   output logic [2:0]                  sel_o,
   // {all byte write_n, write gate_n} and lane strobes
   output logic [1:0]                  wr_o,
   output logic [pbsc_pkg::LANE_N-1:0] byte_n_o,
   // address, write data and asynchronous controls
   output logic [pbsc_pkg::ADDR_W-1:0] addr_o,
   output logic [pbsc_pkg::DATA_W-1:0] data_o,
   output logic                        oe_n_o,
   output logic                        sleep_o
);
   // -------------------------------------------------------------------
   // pin driving
   // -------------------------------------------------------------------
   // idle pins at time zero: no start, no write, bus not enabled
   initial
   begin
      {start_o, sel_o, wr_o, byte_n_o, oe_n_o, sleep_o} = {4'h7, 3'h2, 2'h3, 4'hf, 2'h2};
      addr_o = ADDR_RST;
      data_o = DATA_RST;
   end

   // one bus cycle, launched just after an edge and held until the next one
   task automatic bus(input logic [3:0] st, input logic [2:0] sl, input logic [1:0] w,
                      input logic [LANE_N-1:0] bn, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      logic is_wr;
      is_wr = !w[1] || (!w[0] && bn != LANES_ALL);
      @(posedge clk_i);
      start_o  <= st;
      sel_o    <= sl;
      wr_o     <= w;
      byte_n_o <= bn;
      addr_o   <= a;
      data_o   <= is_wr ? d : ~data_o; // released lines never hold a stale value
      oe_n_o   <= is_wr; // bus enable dropped for the whole write cycle
   endtask

   // the asynchronous output enable pin moves off the clock edge on purpose
   task automatic oe(input logic v);
      oe_n_o = v;
   endtask

   // sleep request changes just after an edge
   task automatic sleep(input logic v);
      @(posedge clk_i);
      sleep_o <= v;
   endtask
endmodule // pbsc_host_model
`default_nettype wire

// ==== pipelined_burst_sram_control_tb_top.sv ====
// self-checking bench for the pipelined burst sram control top
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
   $display("CHECK FAILED %0t got %h want %h", $time, (a), (e)); end end
module pipelined_burst_sram_control_tb_top;
   import pbsc_pkg::*;
   logic                clk;
   logic                rstn;
   logic [3:0]          st;
   logic [2:0]          sl;
   logic [1:0]          wr;
   logic [LANE_N-1:0]   bn, oe, lanes;
   logic [ADDR_W-1:0]   addr, base, a;
   logic [DATA_W-1:0]   din, dout, d;
   logic                oe_n, sleep, low_power, buf_rdy;
   int                  failures, tests_run;
   logic [DATA_W-1:0]   mem [logic [ADDR_W-1:0]];

   pbsc_burst_sram DUT (
      .clk_i(clk), .rstn_i(rstn), .address_in_i(addr),
      .primary_select_n_i(sl[0]), .expansion_select_hi_i(sl[1]),
      .expansion_select_lo_n_i(sl[2]), .processor_burst_start_n_i(st[0]),
      .controller_burst_start_n_i(st[1]), .burst_step_n_i(st[2]),
      .burst_order_select_i(st[3]), .all_byte_write_n_i(wr[1]), .write_gate_n_i(wr[0]),
      .byte_lane_write_n_i(bn), .output_enable_n_i(oe_n), .sleep_request_i(sleep),
      .data_lane_i(din), .data_lane_o(dout), .data_lane_oe_n_o(oe),
      .low_power_o(low_power), .wr_buf_ready_o(buf_rdy));
   pbsc_host_model host (
      .clk_i(clk), .start_o(st), .sel_o(sl), .wr_o(wr), .byte_n_o(bn), .addr_o(addr),
      .data_o(din), .oe_n_o(oe_n), .sleep_o(sleep));

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // expected word after a lane-qualified write
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
                                                input logic [LANE_N-1:0] m);
      for (int g = 0; g < LANE_N; g++)
         if (!m[g])
            o[8*g +: 8] = n[8*g +: 8];
      return o;
   endfunction

   // begin a read, then six no-start cycles with random step; data shows two calls late
   task automatic burst(input logic [ADDR_W-1:0] s, input logic ord, input logic prc);
      logic [ADDR_W-1:0] q [7];
      logic [1:0]        cnt;
      logic              sn;
      cnt = 2'h0;
      q[0] = s;
      host.bus({ord, 1'b1, prc, ~prc}, 3'h2, prc ? 2'($urandom) : 2'h3, 4'($urandom), s, 0);
      for (int k = 1; k < 7; k++)
      begin
         sn = 1'($urandom);
         cnt += {1'b0, ~sn};
         q[k] = ord ? {s[ADDR_W-1:2], s[1:0] ^ cnt} : {s[ADDR_W-1:2], s[1:0] + cnt};
         // primary select high: the processor start must be ignored
         host.bus({ord, sn, 1'b1, 1'($urandom)}, 3'h3, 2'h3, 4'hf, s, 0);
         #1;
         if (k > 1)
         begin
            `CHK(oe, 4'h0)
            `CHK(dout, mem[q[k-2]])
         end
         if (k == 4)
         begin
            host.oe(1'b1);
            #1;
            `CHK(oe, 4'hf)
            host.oe(1'b0);
            #1;
            `CHK(oe, 4'h0)
         end
      end
   endtask

   // verdict and end of run
   task automatic end_sim();
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // hang guard, far beyond the roughly 85 cycles the tests need
   initial
   begin
      #20000;
      failures++;
      end_sim();
   end

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial
   begin
      void'($urandom(69280));
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      #1;
      `CHK(oe, 4'hf)
      `CHK(buf_rdy, 1'b1)
      for (int b = 0; b < 4; b++)
      begin
         base = {15'($urandom), 2'h0};
         for (int i = 0; i < 4; i++)
         begin
            d = $urandom;
            mem[base | 17'(i)] = d;
            // global write with random gate and lane strobes stores all lanes
            host.bus(4'h5, 3'h2, {1'b0, 1'($urandom)}, 4'($urandom), base | 17'(i), d);
         end
         a = base | 17'($urandom % 4);
         lanes = 4'($urandom);
         d = $urandom;
         mem[a] = merge(mem[a], d, lanes);
         host.bus(4'h5, 3'h2, 2'h2, lanes, a, d);
         burst(base | 17'($urandom % 4), b[0], b[1]);
         host.bus(4'h5, 3'h2 ^ (3'h1 << ($urandom % 3)), 2'h3, 4'hf, base, 0);
         for (int k = 1; k < 4; k++)
         begin
            host.bus(4'h3, 3'h2, 2'h3, 4'hf, base, 0);
            #1;
            if (k > 1)
               `CHK(oe, 4'hf)
         end
      end
      // sleep: bus floats, a write meanwhile is lost, contents survive
      // a read is driving when sleep arrives, so the float check can trip
      host.bus(4'h5, 3'h2, 2'h3, 4'hf, base, 0);
      host.bus(4'h3, 3'h2, 2'h3, 4'hf, base, 0);
      host.sleep(1'b1);
      #1;
      `CHK(oe, 4'hf)
      `CHK(low_power, 1'b1)
      host.bus(4'h5, 3'h2, 2'h1, 4'h0, base, ~mem[base]);
      host.bus(4'h3, 3'h2, 2'h3, 4'hf, base, 0);
      host.sleep(1'b0);
      host.bus(4'h3, 3'h2, 2'h3, 4'hf, base, 0);
      #1;
      `CHK(low_power, 1'b1)
      burst(base, 1'b0, 1'b0);
      `CHK(low_power, 1'b0)
      end_sim();
   end
endmodule // pipelined_burst_sram_control_tb_top
`default_nettype wire
